// ### dv/smx_port_mux_test.sv
// Self-checking bench for the system port mux.
// Assumes design sources and the system-side model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "smx_defs.svh"
module smx_port_mux_test;
	typedef struct packed {logic [32:0] v; logic [32:0] m;} smx_note_t;
	smx_note_t notes[$];
	smx_note_t n;
	int err_total = 0, n_tests = 0, cyc = 0;
	logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, run = 0, pin_chk = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, seed = 32'h9fff, rv, prdata;
	logic tx_frame_sync_in = 0, rx_positive_rail = 0, rx_negative_rail = 0, dec_bpv_pulse = 0;
	logic fmt_data_enable_in = 0, fmt_frame_start_in = 0, fmt_payload_ready = 1;
	logic enc_tx_pos = 0, enc_tx_neg = 0, liu_rx_pos = 0, liu_rx_neg = 0, pat_payload_bit = 0;
	logic frm_data_enable_in = 0, frm_frame_start_in = 0, frm_payload_in = 0;
	logic rx_line_clock = 0, liu_rx_clk = 0, tx_clock_pin_out, rx_clock_pin_out;
	logic tx_line_clock, tx_serial_payload_in, pready, pslverr, tx_sync_enable_out;
	logic rx_serial_payload_out, rx_sync_enable_out, fmt_frame_sync_out;
	logic fmt_payload_valid, fmt_payload_bit;
	smx_pkg::smx_rx_line_t dec_rx_line;
	wire logic [9:0] pv = {tx_clock_pin_out, rx_clock_pin_out, tx_sync_enable_out,
		rx_sync_enable_out, fmt_frame_sync_out,
		rx_serial_payload_out, dec_rx_line.pos, dec_rx_line.neg, fmt_payload_valid, fmt_payload_bit};

	smx_port_mux i_smx_port_mux (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .prdata, .pslverr, .tx_line_clock, .tx_frame_sync_in, .tx_serial_payload_in,
		.rx_line_clock, .rx_positive_rail, .rx_negative_rail, .tx_sync_enable_out,
		.tx_clock_pin_out, .rx_serial_payload_out, .rx_sync_enable_out, .rx_clock_pin_out,
		.fmt_data_enable_in, .fmt_frame_start_in, .fmt_frame_sync_out, .fmt_payload_valid,
		.fmt_payload_ready, .fmt_payload_bit, .pat_payload_bit, .enc_tx_pos, .enc_tx_neg,
		.liu_rx_clk, .liu_rx_pos, .liu_rx_neg, .dec_bpv_pulse, .frm_data_enable_in,
		.frm_frame_start_in, .frm_payload_in, .dec_rx_line, .line_cfg(), .frame_cfg());
	smx_sys_model i_smx_sys_model (.sys_clk, .rst, .run, .line_clk(tx_line_clock),
		.payload(tx_serial_payload_in));

	always #25 sys_clk = ~sys_clk;

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Setup then access, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge sys_clk);
		penable <= 1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		{psel, penable} <= 2'b00;
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] v, input logic [32:0] m);
		notes.push_back('{v & m, m});
		apb(0, a, 32'h0);
	endtask
	task automatic pins(input logic [9:0] v, input logic [9:0] m);
		@(posedge sys_clk);
		pin_chk <= 1;
		notes.push_back('{{23'h0, v & m}, {23'h0, m}});
		@(posedge sys_clk);
		pin_chk <= 0;
	endtask
	function automatic logic [31:0] ctl(input logic [8:0] b, input logic [2:0] l, input logic [2:0] f);
		return {17'h0, b, l, f};
	endfunction
	function automatic logic [31:0] st_exp(input logic [2:0] f, input logic [2:0] l, input logic z);
		logic e3;
		logic [3:0] c;
		e3 = f == 3'b010 || f == 3'b011 || f == 3'b110;
		c = l[2] ? 4'h8 : z ? 4'h4 : e3 ? 4'h2 : 4'h1;
		return {16'h0, c, c, l == 3'b011, l == 3'b010, l != 3'b000 && !l[2], l[2],
			f[2] && f[0], e3, f == 3'b000 || f == 3'b001 || f == 3'b100, !f[2]};
	endfunction

	// Result watcher: oldest note against each read answer or pin probe
	always @(posedge sys_clk) begin
		if ((psel && penable && pready && !pwrite) || pin_chk) begin
			if (notes.size() == 0) check(33'h1, 33'h0);
			else begin
				n = notes.pop_front();
				check((pin_chk ? {23'h0, pv} : {pslverr, prdata}) & n.m, n.v);
			end
		end
	end
	// Hang guard, well above the planned run
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			end_sim;
		end
	end

	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 0;
		rd(`SMX_OFF_CTRL, 33'h0, 33'h1ffffffff);
		rd(`SMX_OFF_STATUS, 33'h1103, 33'h10000ffff);
		rd(8'h0c, 33'h100000000, 33'h1ffffffff);
		$display("reset test done");
		for (int f = 0; f < 8; f++) begin
			for (int l = 0; l < 8; l++) begin
				rv = $random(seed);
				apb(1, `SMX_OFF_CTRL, ctl({2'b0, rv[1:0], 5'h0}, l[2:0], f[2:0]));
				rd(`SMX_OFF_STATUS, {1'b0, st_exp(f[2:0], l[2:0], &rv[1:0])},
					(f[2] && f[0]) ? 33'h1000000ff : 33'h10000ffff);
			end
		end
		$display("decode test done");
		for (int i = 0; i < 24; i++) begin
			rv = $random(seed);
			tx_frame_sync_in <= rv[20];
			repeat (6) @(posedge sys_clk);
			apb(1, `SMX_OFF_CTRL, ctl({rv[8], 3'h0, rv[4:0]}, 3'b001, rv[18:16]));
			@(posedge sys_clk);
			{liu_rx_clk, fmt_data_enable_in, fmt_frame_start_in, frm_data_enable_in,
				frm_frame_start_in, frm_payload_in, pat_payload_bit} <= rv[30:24];
			pins({1'b0, rv[30] & (rv[18] | rv[4] | rv[27]),
				rv[18] | (rv[1] ? rv[28] : rv[29]), rv[18] | (rv[3] ? rv[26] : rv[27]),
				!rv[18] & rv[0] & rv[20], rv[25], 2'b00, rv[8], rv[24]},
				{2'b11, 6'h3c, 1'b1, rv[8]});
		end
		$display("pin mux test done");
		{rx_positive_rail, rx_negative_rail, liu_rx_pos, liu_rx_neg, enc_tx_pos, enc_tx_neg} <= 6'b100111;
		for (int k = 0; k < 3; k++) begin
			apb(1, `SMX_OFF_CTRL, ctl({1'b0, k == 2, 7'h0}, {2'b00, k == 1}, 3'b000));
			repeat (8) @(posedge sys_clk);
			pins({4'h0, k == 0 ? 2'b10 : k == 1 ? 2'b01 : 2'b11, 2'b00}, 8'h0c);
		end
		$display("receive path test done");
		rx_negative_rail <= 1;
		// Bipolar counts decoder pulses; unipolar counts violation pin on clock rises
		for (int u = 0; u < 2; u++) begin
			apb(1, `SMX_OFF_CTRL, ctl(9'h0, {u[0], 2'b00}, 3'b000));
			apb(1, `SMX_OFF_BPVCNT, 32'h0);
			rv = $random(seed);
			repeat (rv[2:0] + 1) begin
				@(posedge sys_clk);
				dec_bpv_pulse <= !u[0];
				rx_line_clock <= u[0];
				@(posedge sys_clk);
				dec_bpv_pulse <= 0;
				repeat (4) @(posedge sys_clk);
				rx_line_clock <= 0;
				repeat (4) @(posedge sys_clk);
			end
			rd(`SMX_OFF_BPVCNT, {30'h0, rv[2:0]} + 33'h1, 33'h10000ffff);
			if (u) pins(8'h08, 8'h0c);
		end
		$display("violation count test done");
		apb(1, `SMX_OFF_CTRL, ctl(9'h0, 3'b000, 3'b100));
		fmt_payload_ready <= 0;
		apb(1, `SMX_OFF_STATUS, 32'h10000);
		run <= 1;
		repeat (200) @(posedge sys_clk);
		run <= 0;
		rd(`SMX_OFF_STATUS, 33'h10000, 33'h100010000);
		pins(8'h02, 8'h02);
		fmt_payload_ready <= 1;
		repeat (8) @(posedge sys_clk);
		pins(8'h00, 8'h02);
		apb(1, `SMX_OFF_STATUS, 32'h10000);
		rd(`SMX_OFF_STATUS, 33'h0, 33'h100010000);
		$display("buffer test done");
		end_sim;
	end
endmodule
`default_nettype wire

// ### dv/smx_sys_model.sv
// System-side model: line clock and payload bits toward the transmit pins.
// Assumes one sys_clk; the line clock stands low while run is low.
`timescale 1ns/1ps
`default_nettype none
module smx_sys_model (
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic run,
	output logic      line_clk,
	output logic      payload
);
	logic [3:0] half_cnt;
	logic [7:0] lfsr;
	// payload settled at rise
	// Bit moves after the falling edge; idle line toggles so stale bits never look valid
	always_ff @(posedge sys_clk) begin
		if (rst || !run) begin
			half_cnt <= 4'h0;
			line_clk <= 1'b0;
			payload <= rst ? 1'b0 : !payload;
			lfsr <= rst ? 8'h5a : lfsr;
		end else begin
			half_cnt <= half_cnt + 4'h1;
			if (half_cnt == 4'hf) begin
				line_clk <= !line_clk;
				lfsr <= line_clk ? {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]} : lfsr;
				payload <= line_clk ? lfsr[0] : payload;
			end
		end
	end
endmodule
`default_nettype wire

// ### hw/smx_defs.svh
// Offsets, field positions, reset values and codes of the system port mux.
// Assumes inclusion by bare name from the package and the mux module.
`ifndef SMX_DEFS_SVH
`define SMX_DEFS_SVH

// Register byte offsets on the APB slave
`define SMX_OFF_CTRL     8'h00
`define SMX_OFF_STATUS   8'h04
`define SMX_OFF_BPVCNT   8'h08

// Widths and reset values
`define SMX_CTRL_W       15
`define SMX_CTRL_RESET   15'h0000
`define SMX_BPV_W        16
`define SMX_STAT_OVF_BIT 16
`define SMX_FIFO_DEPTH   4

// Synchronised pin indices
`define SMX_PIN_N        6
`define SMX_PIN_TXC      0
`define SMX_PIN_TXFS     1
`define SMX_PIN_TXD      2
`define SMX_PIN_RXC      3
`define SMX_PIN_RXP      4
`define SMX_PIN_RXN      5

// Framing and line mode codes
`define SMX_FRAME_DS3_CBIT 3'b000
`define SMX_FRAME_DS3_M23  3'b001
`define SMX_FRAME_DS3_UFRM 3'b100
`define SMX_LINE_LIU_OFF   3'b000
`define SMX_LINE_JA_TX     3'b010
`define SMX_LINE_JA_RX     3'b011

`endif

// ### hw/smx_fifo.sv
// Small valid/ready FIFO for the transmit payload bits.
// Assumes one clock, synchronous active-high reset, DEPTH a power of two.
`timescale 1ns/1ps
`default_nettype none

module smx_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 4
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// Refuse depths the pointer arithmetic cannot serve
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_param
		$error("smx_fifo: DEPTH must be a power of two >= 2, WIDTH >= 1");
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0]                 wptr;
		logic [AW:0]                 rptr;
	} smx_fifo_state_t;

	smx_fifo_state_t st;
	smx_fifo_state_t nxt_st;
	logic [AW:0]     fill;

	// Extra pointer bit tells full from empty
	assign fill      = st.wptr - st.rptr;
	assign in_ready  = (fill != (AW+1)'(DEPTH));
	assign out_valid = (fill != '0);
	assign out_data  = st.mem[st.rptr[AW-1:0]];

	// Push and pop may share a cycle
	always_comb begin
		nxt_st = st;
		if (in_valid && in_ready) begin
			nxt_st.mem[st.wptr[AW-1:0]] = in_data;
			nxt_st.wptr                 = st.wptr + 1'b1;
		end
		if (out_valid && out_ready) begin
			nxt_st.rptr = st.rptr + 1'b1;
		end
	end

	// Pointers cleared on reset, contents left alone
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st.wptr <= '0;
			st.rptr <= '0;
		end else begin
			st <= nxt_st;
		end
	end

endmodule

`default_nettype wire

// ### hw/smx_pkg.sv
// Types shared by the system port mux and its users.
// Assumes smx_defs.svh is on the include path.
`include "smx_defs.svh"

package smx_pkg;

	// Line coding chosen for one direction
	typedef enum logic [3:0] {
		SMX_LC_B3ZS     = 4'b0001,
		SMX_LC_HDB3     = 4'b0010,
		SMX_LC_AMI      = 4'b0100,
		SMX_LC_UNIPOLAR = 4'b1000
	} smx_line_code_t;

	// Control register layout, lsb first at the bottom
	typedef struct packed {
		logic       pattern_test_enable;
		logic       analog_loopback;
		logic       rx_zero_suppress_disable;
		logic       tx_zero_suppress_disable;
		logic       rx_clock_out_select;
		logic       rx_sync_out_select;
		logic       tx_clock_out_select;
		logic       tx_sync_out_select;
		logic       tx_sync_pin_enable;
		logic [2:0] line_mode_code;
		logic [2:0] framing_mode_code;
	} smx_ctrl_t;

	// Selection handed to the encoder/decoder, line units and attenuator
	typedef struct packed {
		smx_line_code_t tx_code;
		smx_line_code_t rx_code;
		logic           liu_tx_on;
		logic           liu_rx_on;
		logic           ja_in_tx;
		logic           ja_in_rx;
		logic           liu_analog_loop;
		logic           unipolar_line_mode;
	} smx_line_cfg_t;

	// Selection handed to framer, formatter and pattern tester
	typedef struct packed {
		logic [2:0] framing_mode_code;
		logic       framed;
		logic       ds3;
		logic       e3;
		logic       undefined;
		logic       framer_enable;
		logic       pattern_test_enable;
	} smx_frame_cfg_t;

	// Receive line signals toward the decoder
	typedef struct packed {
		logic line_clk;
		logic pos;
		logic neg;
	} smx_rx_line_t;

	// Whole state of the mux module
	typedef struct packed {
		smx_ctrl_t                ctrl;
		logic [31:0]              rdata;
		logic [`SMX_BPV_W-1:0]    bpv_cnt;
		logic                     ovf;
		logic [`SMX_PIN_N-1:0]    s1;
		logic [`SMX_PIN_N-1:0]    s2;
		logic [`SMX_PIN_N-1:0]    s3;
		logic [`SMX_PIN_N-1:0]    filt;
		logic                     tx_den_q;
		logic                     tx_fsync;
		logic                     tx_sync_en;
		logic                     tx_clk;
		logic                     rx_payload;
		logic                     rx_sync_en;
		logic                     rx_clk;
		smx_rx_line_t             rx_line;
		smx_line_cfg_t            line_cfg;
		smx_frame_cfg_t           frame_cfg;
	} smx_state_t;

endpackage

// ### hw/smx_port_mux.sv
// System port pin multiplexer with framing and line mode decode.
// Assumes an APB master on sys_clk, line pins far slower than sys_clk,
// and framer, formatter, encoder and line units on sys_clk.
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "smx_defs.svh"

// Function
// - Unused multiplexed input functions feed constant zero inward.
// - Transmit frame-sync input honoured only in framed modes.
// - Transmit sync pin: enable or frame start when framed, high when unframed.
// - Transmit clock gapped by enable only when framed with select zero.
// - Receive sync pin: enable or frame start when framed, high when unframed.
// - Receive clock gapped by enable only when framed with select zero.
// - Decode the framing code into DS3/E3, framed/unframed, undefined.
// - Line coding is decoded from both the framing and line mode codes.
// - Pattern tester may be enabled in every framing mode.
// - Decode line mode into line unit and attenuator selection.
// - Bipolar modes use B3ZS for DS3 and HDB3 for E3.
// - Both zero-suppress disables set give AMI unless unipolar.
// - Unipolar mode counts external pulses on the violation input.
// - Analog loopback needs line units on; with them off the loop is digital.
// - Receive framer input from line unit or pins; transmit from payload pin.
// - Pattern generator replaces transmit payload; enables stay active.
module smx_port_mux #(
	parameter int FIFO_DEPTH = `SMX_FIFO_DEPTH
) (
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic                       pready,
	output logic      [31:0]           prdata,
	output logic                       pslverr,
	input  wire logic                  tx_line_clock,
	input  wire logic                  tx_frame_sync_in,
	input  wire logic                  tx_serial_payload_in,
	input  wire logic                  rx_line_clock,
	input  wire logic                  rx_positive_rail,
	input  wire logic                  rx_negative_rail,
	output logic                       tx_sync_enable_out,
	output logic                       tx_clock_pin_out,
	output logic                       rx_serial_payload_out,
	output logic                       rx_sync_enable_out,
	output logic                       rx_clock_pin_out,
	input  wire logic                  fmt_data_enable_in,
	input  wire logic                  fmt_frame_start_in,
	output logic                       fmt_frame_sync_out,
	output logic                       fmt_payload_valid,
	input  wire logic                  fmt_payload_ready,
	output logic                       fmt_payload_bit,
	input  wire logic                  pat_payload_bit,
	input  wire logic                  enc_tx_pos,
	input  wire logic                  enc_tx_neg,
	input  wire logic                  liu_rx_clk,
	input  wire logic                  liu_rx_pos,
	input  wire logic                  liu_rx_neg,
	input  wire logic                  dec_bpv_pulse,
	input  wire logic                  frm_data_enable_in,
	input  wire logic                  frm_frame_start_in,
	input  wire logic                  frm_payload_in,
	output smx_pkg::smx_rx_line_t      dec_rx_line,
	output smx_pkg::smx_line_cfg_t     line_cfg,
	output smx_pkg::smx_frame_cfg_t    frame_cfg
);

	// Refuse a FIFO too shallow to absorb the enable lag
	if (FIFO_DEPTH < 2) begin : g_bad_depth
		$error("smx_port_mux: FIFO_DEPTH must be at least 2");
	end

	smx_pkg::smx_state_t st;
	smx_pkg::smx_state_t nxt_st;

	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_data;
	logic fifo_push;
	logic fifo_pop_ready;
	logic tx_den_eff;

	// FIFO between the payload pin and the formatter
	smx_fifo #(
		.WIDTH (1),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.in_valid  (fifo_push),
		.in_ready  (fifo_in_ready),
		.in_data   (st.filt[`SMX_PIN_TXD]),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop_ready),
		.out_data  (fifo_out_data)
	);

	// Enable shown to the system is withheld while the FIFO is full
	assign tx_den_eff = fmt_data_enable_in & fifo_in_ready;

	// pattern replaces payload
	// Serial input is drained and discarded while the tester drives
	assign fifo_pop_ready    = st.ctrl.pattern_test_enable | fmt_payload_ready;
	assign fmt_payload_valid = st.ctrl.pattern_test_enable | fifo_out_valid;
	assign fmt_payload_bit   = st.ctrl.pattern_test_enable ? pat_payload_bit : fifo_out_data;

	// APB answers with no wait state
	assign pready  = psel & penable;
	assign pslverr = psel & penable & ~(paddr == `SMX_OFF_CTRL || paddr == `SMX_OFF_STATUS
		|| paddr == `SMX_OFF_BPVCNT);
	assign prdata  = st.rdata;

	// Registered pin and internal outputs
	assign tx_sync_enable_out    = st.tx_sync_en;
	assign tx_clock_pin_out      = st.tx_clk;
	assign rx_serial_payload_out = st.rx_payload;
	assign rx_sync_enable_out    = st.rx_sync_en;
	assign rx_clock_pin_out      = st.rx_clk;
	assign fmt_frame_sync_out    = st.tx_fsync;
	assign dec_rx_line           = st.rx_line;
	assign line_cfg              = st.line_cfg;
	assign frame_cfg             = st.frame_cfg;

	// Push on each transmit line clock rise; framed modes need the enable
	assign fifo_push = ~st.ctrl.pattern_test_enable
		& ~st.filt[`SMX_PIN_TXC] & st.s3[`SMX_PIN_TXC] & (st.s2[`SMX_PIN_TXC] == st.s3[`SMX_PIN_TXC])
		& (st.ctrl.framing_mode_code[2] | st.tx_den_q);

	// Decode, pin muxing, loopback routing and register file
	always_comb begin
		logic                    framed;
		logic                    undef;
		logic                    ds3;
		logic                    e3;
		logic                    unipolar;
		logic                    liu_on;
		logic                    rx_rise;
		logic                    bpv_event;
		logic                    wr;
		logic                    mapped;
		smx_pkg::smx_line_code_t bip_code;
		logic [31:0]             status;
		framed    = 1'b0;
		undef     = 1'b0;
		ds3       = 1'b0;
		e3        = 1'b0;
		unipolar  = 1'b0;
		liu_on    = 1'b0;
		rx_rise   = 1'b0;
		bpv_event = 1'b0;
		wr        = 1'b0;
		mapped    = 1'b0;
		bip_code  = smx_pkg::SMX_LC_B3ZS;
		status    = '0;
		nxt_st    = st;

		// Three-stage pin capture; a change counts once stages two and three agree
		nxt_st.s1 = {rx_negative_rail, rx_positive_rail, rx_line_clock,
			tx_serial_payload_in, tx_frame_sync_in, tx_line_clock};
		nxt_st.s2 = st.s1;
		nxt_st.s3 = st.s2;
		for (int i = 0; i < `SMX_PIN_N; i++) begin
			if (st.s2[i] == st.s3[i]) begin
				nxt_st.filt[i] = st.s3[i];
			end
		end

		framed = ~st.ctrl.framing_mode_code[2];
		undef  = st.ctrl.framing_mode_code[2] & st.ctrl.framing_mode_code[0];
		ds3    = ~st.ctrl.framing_mode_code[1] & ~undef;
		e3     = st.ctrl.framing_mode_code[1] & ~undef;
		nxt_st.frame_cfg.framing_mode_code = st.ctrl.framing_mode_code;
		nxt_st.frame_cfg.framed            = framed;
		nxt_st.frame_cfg.ds3               = ds3;
		nxt_st.frame_cfg.e3                = e3;
		nxt_st.frame_cfg.undefined         = undef;
		nxt_st.frame_cfg.framer_enable     = ~undef;
		nxt_st.frame_cfg.pattern_test_enable = st.ctrl.pattern_test_enable;

		unipolar = st.ctrl.line_mode_code[2];
		liu_on   = ~unipolar && st.ctrl.line_mode_code != `SMX_LINE_LIU_OFF;
		nxt_st.line_cfg.unipolar_line_mode = unipolar;
		nxt_st.line_cfg.liu_tx_on          = liu_on;
		nxt_st.line_cfg.liu_rx_on          = liu_on;
		nxt_st.line_cfg.ja_in_tx           = st.ctrl.line_mode_code == `SMX_LINE_JA_TX;
		nxt_st.line_cfg.ja_in_rx           = st.ctrl.line_mode_code == `SMX_LINE_JA_RX;
		nxt_st.line_cfg.liu_analog_loop    = st.ctrl.analog_loopback & liu_on;

		bip_code = e3 ? smx_pkg::SMX_LC_HDB3 : smx_pkg::SMX_LC_B3ZS;
		if (unipolar) begin
			nxt_st.line_cfg.tx_code = smx_pkg::SMX_LC_UNIPOLAR;
		end else if (st.ctrl.tx_zero_suppress_disable && st.ctrl.rx_zero_suppress_disable) begin
			nxt_st.line_cfg.tx_code = smx_pkg::SMX_LC_AMI;
		end else begin
			nxt_st.line_cfg.tx_code = bip_code;
		end
		nxt_st.line_cfg.rx_code = nxt_st.line_cfg.tx_code;

		// digital loopback when line units off
		if (liu_on) begin
			nxt_st.rx_line.line_clk = liu_rx_clk;
			nxt_st.rx_line.pos      = liu_rx_pos;
			nxt_st.rx_line.neg      = liu_rx_neg;
		end else if (st.ctrl.analog_loopback) begin
			nxt_st.rx_line.line_clk = nxt_st.filt[`SMX_PIN_TXC];
			nxt_st.rx_line.pos      = enc_tx_pos;
			nxt_st.rx_line.neg      = enc_tx_neg & ~unipolar;
		end else begin
			nxt_st.rx_line.line_clk = nxt_st.filt[`SMX_PIN_RXC];
			nxt_st.rx_line.pos      = nxt_st.filt[`SMX_PIN_RXP];
			// violation pin is no rail in unipolar
			nxt_st.rx_line.neg      = nxt_st.filt[`SMX_PIN_RXN] & ~unipolar;
		end

		nxt_st.tx_fsync = framed & st.ctrl.tx_sync_pin_enable & nxt_st.filt[`SMX_PIN_TXFS];
		nxt_st.tx_den_q = tx_den_eff;

		if (!framed) begin
			nxt_st.tx_sync_en = 1'b1;
		end else begin
			nxt_st.tx_sync_en = st.ctrl.tx_sync_out_select ? fmt_frame_start_in : tx_den_eff;
		end
		if (framed && !st.ctrl.tx_clock_out_select) begin
			nxt_st.tx_clk = nxt_st.filt[`SMX_PIN_TXC] & tx_den_eff;
		end else begin
			nxt_st.tx_clk = nxt_st.filt[`SMX_PIN_TXC];
		end

		nxt_st.rx_payload = frm_payload_in;
		if (!framed) begin
			nxt_st.rx_sync_en = 1'b1;
		end else begin
			nxt_st.rx_sync_en = st.ctrl.rx_sync_out_select ? frm_frame_start_in
				: frm_data_enable_in;
		end
		if (framed && !st.ctrl.rx_clock_out_select) begin
			nxt_st.rx_clk = nxt_st.rx_line.line_clk & frm_data_enable_in;
		end else begin
			nxt_st.rx_clk = nxt_st.rx_line.line_clk;
		end

		rx_rise   = nxt_st.rx_line.line_clk & ~st.rx_line.line_clk;
		bpv_event = unipolar ? (rx_rise & nxt_st.filt[`SMX_PIN_RXN]) : dec_bpv_pulse;

		// Register access; a hardware event beats a clear in the same cycle
		wr     = psel & penable & pwrite;
		mapped = paddr == `SMX_OFF_CTRL || paddr == `SMX_OFF_STATUS
			|| paddr == `SMX_OFF_BPVCNT;
		if (wr && paddr == `SMX_OFF_CTRL) begin
			nxt_st.ctrl = smx_pkg::smx_ctrl_t'(pwdata[`SMX_CTRL_W-1:0]);
		end
		if (wr && paddr == `SMX_OFF_BPVCNT) begin
			nxt_st.bpv_cnt = {{(`SMX_BPV_W-1){1'b0}}, bpv_event};
		end else if (bpv_event && !(&st.bpv_cnt)) begin
			nxt_st.bpv_cnt = st.bpv_cnt + `SMX_BPV_W'(1);
		end
		if (wr && paddr == `SMX_OFF_STATUS && pwdata[`SMX_STAT_OVF_BIT]) begin
			nxt_st.ovf = 1'b0;
		end
		// Unframed modes push with no enable, so a stalled formatter can lose bits
		if (fifo_push && !fifo_in_ready) begin
			nxt_st.ovf = 1'b1;
		end

		// Read data captured in the setup cycle
		status = {15'h0000, st.ovf, st.line_cfg.rx_code, st.line_cfg.tx_code,
			st.line_cfg.ja_in_rx, st.line_cfg.ja_in_tx, st.line_cfg.liu_tx_on,
			st.line_cfg.unipolar_line_mode, st.frame_cfg.undefined, st.frame_cfg.e3,
			st.frame_cfg.ds3, st.frame_cfg.framed};
		if (psel && !penable) begin
			if (!mapped || pwrite) begin
				nxt_st.rdata = 32'h0000_0000;
			end else if (paddr == `SMX_OFF_CTRL) begin
				nxt_st.rdata = {17'h00000, st.ctrl};
			end else if (paddr == `SMX_OFF_STATUS) begin
				nxt_st.rdata = status;
			end else begin
				nxt_st.rdata = {16'h0000, st.bpv_cnt};
			end
		end
	end

	// State register with synchronous reset
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st      <= '0;
			st.ctrl <= `SMX_CTRL_RESET;
			st.line_cfg.tx_code <= smx_pkg::SMX_LC_B3ZS;
			st.line_cfg.rx_code <= smx_pkg::SMX_LC_B3ZS;
			st.frame_cfg.framed <= 1'b1;
			st.frame_cfg.ds3    <= 1'b1;
			st.frame_cfg.framer_enable <= 1'b1;
			st.tx_sync_en <= 1'b0;
		end else begin
			st <= nxt_st;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	unused_sync_zero_a: assert property (
		st.ctrl.framing_mode_code[2] |=> !fmt_frame_sync_out)
		else $error("frame sync reached formatter in unframed mode");
	tx_sync_high_a: assert property (
		st.ctrl.framing_mode_code[2] |=> tx_sync_enable_out)
		else $error("tx sync pin not high in unframed mode");
	tx_sync_sel_a: assert property (
		!st.ctrl.framing_mode_code[2] && st.ctrl.tx_sync_out_select
		|=> tx_sync_enable_out == $past(fmt_frame_start_in))
		else $error("tx sync pin does not carry frame start");
	tx_clk_gap_a: assert property (
		!st.ctrl.framing_mode_code[2] && !st.ctrl.tx_clock_out_select && !fmt_data_enable_in
		|=> !tx_clock_pin_out)
		else $error("tx gapped clock high without enable");
	tx_clk_plain_a: assert property (
		st.ctrl.framing_mode_code[2] || st.ctrl.tx_clock_out_select
		|=> tx_clock_pin_out == st.filt[`SMX_PIN_TXC])
		else $error("tx plain clock not following line clock");
	rx_sync_high_a: assert property (
		st.ctrl.framing_mode_code[2] |=> rx_sync_enable_out)
		else $error("rx sync pin not high in unframed mode");
	rx_clk_gap_a: assert property (
		!st.ctrl.framing_mode_code[2] && !st.ctrl.rx_clock_out_select && !frm_data_enable_in
		|=> !rx_clock_pin_out)
		else $error("rx gapped clock high without enable");
	mode_decode_a: assert property (
		##1 frame_cfg.ds3 == ($past(st.ctrl.framing_mode_code) inside
		{`SMX_FRAME_DS3_CBIT, `SMX_FRAME_DS3_M23, `SMX_FRAME_DS3_UFRM}))
		else $error("DS3 decode wrong");
	line_decode_a: assert property (
		st.ctrl.line_mode_code == `SMX_LINE_JA_RX |=> line_cfg.ja_in_rx && line_cfg.liu_rx_on
		&& !line_cfg.ja_in_tx)
		else $error("attenuator not placed in receive path");
	ami_select_a: assert property (
		!st.ctrl.line_mode_code[2] && st.ctrl.tx_zero_suppress_disable
		&& st.ctrl.rx_zero_suppress_disable |=> line_cfg.tx_code == smx_pkg::SMX_LC_AMI)
		else $error("AMI not selected");
	loop_route_a: assert property (
		!line_cfg.liu_rx_on && st.ctrl.analog_loopback && !st.line_cfg.unipolar_line_mode
		&& st.ctrl.line_mode_code == `SMX_LINE_LIU_OFF |=> dec_rx_line.pos == $past(enc_tx_pos))
		else $error("digital loopback not routed");
	pattern_sel_a: assert property (
		st.ctrl.pattern_test_enable |-> fmt_payload_valid && fmt_payload_bit == pat_payload_bit)
		else $error("pattern generator not driving payload");
	// Receive clock rise with violation pin high must step the count
	bpv_count_a: assert property (
		$rose(dec_rx_line.line_clk) && $past(st.ctrl.line_mode_code[2])
		&& st.filt[`SMX_PIN_RXN] && !$past(psel && penable && pwrite)
		&& $past(st.bpv_cnt) != 16'hffff |-> st.bpv_cnt == $past(st.bpv_cnt) + 16'h0001)
		else $error("pulse counter did not step");

endmodule

`default_nettype wire
